// ---- bench/ctu_far_model.sv ----
/*
 * ctu_far_model: far side of the charge-time edge control block.
 * Holds the two edge pins, the two capture-compare trigger levels and
 * the delay comparator. Assumes the bench sets the wanted levels just
 * after a pclk edge; the model launches them on the next edge.
 */
`timescale 1ns/10ps
`default_nettype none

module ctu_far_model (
    input  wire logic       pclk,
    input  wire logic [3:0] lvl_req,
    input  wire logic       trip_req,
    output logic            edge_pin_one,
    output logic            edge_pin_two,
    output logic            capture_compare_one,
    output logic            capture_compare_two,
    output logic            delay_comparator
);
    logic [3:0] lvl_q = 4'h0;
    logic       trip_q = 1'b0;

    // sources move on the edge; trigger levels are same-clock signals
    always @(posedge pclk) begin
        lvl_q  <= lvl_req;
        trip_q <= trip_req;
    end

    // pins and comparator are asynchronous, so land them off the edge
    assign #3 edge_pin_one     = lvl_q[3];
    assign #3 edge_pin_two     = lvl_q[2];
    assign #3 delay_comparator = trip_q;
    assign capture_compare_one = lvl_q[1];
    assign capture_compare_two = lvl_q[0];
endmodule

`default_nettype wire

// ---- bench/tb.sv ----
/*
 * tb: self-checking bench for ctu_edge_ctrl. Random and corner register
 * traffic over APB plus edge, sequencing, gating and power scenarios.
 * Assumes ctu_pkg, ctu_edge_ctrl and ctu_far_model are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, cur_on, chg_en, dis, dly, trig;
    logic [1:0]  cur_rng;
    logic [5:0]  cur_trim;
    logic        pdis = 1'b0;
    logic        idle_m = 1'b0;
    logic        sleep_m = 1'b0;
    logic [3:0]  lvl = 4'h0;
    logic        trip = 1'b0;
    logic        p1, p2, c1, c2, cmp, slv;
    logic [7:0]  r, ev, d;
    int          errors = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          trig_n = 0;
    integer      seed = 24;
    logic [7:0]  corner [3] = '{8'h7C, 8'h84, 8'h00};

    always #5 pclk = ~pclk;

    ctu_far_model far_u (.pclk(pclk), .lvl_req(lvl), .trip_req(trip),
        .edge_pin_one(p1), .edge_pin_two(p2), .capture_compare_one(c1),
        .capture_compare_two(c2), .delay_comparator(cmp));

    ctu_edge_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .peripheral_disable(pdis),
        .idle_mode(idle_m), .sleep_mode(sleep_m), .edge_pin_one(p1),
        .edge_pin_two(p2), .capture_compare_one(c1),
        .capture_compare_two(c2), .delay_comparator(cmp),
        .current_on(cur_on), .current_range(cur_rng),
        .current_trim(cur_trim), .charge_enable(chg_en),
        .source_discharge(dis), .delay_pulse_out(dly),
        .special_trigger_out(trig));

    // hang guard and trigger pulse counter
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (trig === 1'b1)
            trig_n <= trig_n + 1;
        if (cyc == 20000) begin
            errors = errors + 1;
            finish_test();
        end
    end

    // current source on only when enabled, ranged and awake
    function automatic logic exp_on(logic [7:0] h, logic [7:0] c);
        return h[7] & (c[1:0] != 2'h0) & ~sleep_m;
    endfunction

    task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("FAIL t=%0t %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic wait_clk(int n);
        repeat (n) @(posedge pclk);
    endtask

    // one apb transfer; held until pready is seen high at an edge
    task automatic apb(logic w, logic [7:0] a, logic [7:0] wd,
                       output logic [7:0] rd);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h0, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd  = prdata[7:0];
        slv = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // main sequence
    initial begin
        wait_clk(5);
        presetn <= 1'b1;
        apb(0, ctu_pkg::OFF_CTL_HIGH, 8'h00, r);
        chk(r, ctu_pkg::RST_CTL_HIGH, "ctl high reset");
        apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
        chk(r, ctu_pkg::RST_EDGE_CTL, "edge reset");
        apb(0, ctu_pkg::OFF_CUR_CTL, 8'h00, r);
        chk(r, ctu_pkg::RST_CUR_CTL, "cur reset");
        apb(0, 8'h0C, 8'h00, r);
        chk({slv, r}, 9'h100, "unmapped read");
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'hFF, r);
        apb(0, ctu_pkg::OFF_CTL_HIGH, 8'h00, r);
        chk(r, 8'hBF, "unused bit");
        chk(dis, 1'b1, "discharge on");
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'h80, r);
        wait_clk(1);
        chk(dis, 1'b0, "discharge off");
        $display("test registers done");
        // corner then random current settings
        for (int i = 0; i < 11; i++) begin
            d = (i < 3) ? corner[i] : 8'($random(seed));
            apb(1, ctu_pkg::OFF_CUR_CTL, d, r);
            apb(0, ctu_pkg::OFF_CUR_CTL, 8'h00, r);
            chk(r, d, "cur readback");
            chk({cur_trim, cur_rng}, d, "trim range out");
            chk(cur_on, exp_on(8'h80, d), "current on");
        end
        apb(1, ctu_pkg::OFF_CUR_CTL, 8'h05, r);
        sleep_m <= 1'b1;
        wait_clk(2);
        chk(cur_on, exp_on(8'h80, 8'h05), "sleep off");
        sleep_m <= 1'b0;
        wait_clk(2);
        chk(cur_on, exp_on(8'h80, 8'h05), "awake on");
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'h00, r);
        wait_clk(1);
        chk(cur_on, 1'b0, "unit off");
        $display("test current done");
        // every source and polarity; edge two on the opposite transition
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'h88, r);
        for (int s = 0; s < 4; s++) begin
            for (int p = 0; p < 2; p++) begin
                lvl[s] <= ~p[0];
                wait_clk(6);
                ev = {~p[0], 2'(s), p[0], 2'(s), 2'b00};
                apb(1, ctu_pkg::OFF_EDGE_CTL, ev, r);
                apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
                chk(r, ev, "no edge yet");
                lvl[s] <= p[0];
                wait_clk(6);
                apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
                chk(r, ev | 8'h01, "edge one");
                chk(chg_en, 1'b1, "charging");
                lvl[s] <= ~p[0];
                wait_clk(6);
                apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
                chk(r, ev | 8'h03, "edge two");
                chk(chg_en, 1'b0, "charge stop");
            end
        end
        chk(trig_n, 0, "no trigger when off");
        $display("test edges done");
        // gate closed, then stop in idle: edges ignored
        ev = 8'hB4;
        apb(1, ctu_pkg::OFF_EDGE_CTL, ev, r);
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'h80, r);
        lvl[1] <= 1'b1;
        wait_clk(4);
        apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
        chk(r, ev, "gate blocks");
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'hA8, r);
        idle_m <= 1'b1;
        lvl[1] <= 1'b0;
        wait_clk(2);
        lvl[1] <= 1'b1;
        wait_clk(4);
        apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
        chk(r, ev, "idle halts");
        idle_m <= 1'b0;
        lvl[1] <= 1'b0;
        $display("test blocking done");
        // sequencing: edge two alone refused, then accepted after one
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'h8D, r);
        ev = 8'hB0;
        apb(1, ctu_pkg::OFF_EDGE_CTL, ev, r);
        lvl[1] <= 1'b1;
        wait_clk(4);
        apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
        chk(r, ev, "two before one");
        lvl[1] <= 1'b0;
        lvl[0] <= 1'b1;
        wait_clk(4);
        lvl[1] <= 1'b1;
        wait_clk(4);
        apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
        chk(r, ev | 8'h03, "ordered pair");
        chk(trig_n, 1, "one trigger pulse");
        $display("test sequence done");
        // delay pulse follows status until the comparator trips
        apb(1, ctu_pkg::OFF_CTL_HIGH, 8'h98, r);
        apb(1, ctu_pkg::OFF_EDGE_CTL, 8'h01, r);
        wait_clk(4);
        chk(dly, 1'b1, "pulse high");
        trip <= 1'b1;
        wait_clk(5);
        chk(dly, 1'b0, "pulse ends");
        $display("test delay done");
        // disabled unit: reads zero, writes dropped, state kept
        pdis <= 1'b1;
        apb(0, ctu_pkg::OFF_CTL_HIGH, 8'h00, r);
        chk(r, 8'h00, "disabled read");
        apb(1, ctu_pkg::OFF_CUR_CTL, 8'h03, r);
        pdis <= 1'b0;
        apb(0, ctu_pkg::OFF_CUR_CTL, 8'h00, r);
        chk(r, 8'h05, "write dropped");
        // reset in mid measurement loses the result
        @(posedge pclk);
        presetn <= 1'b0;
        wait_clk(3);
        presetn <= 1'b1;
        apb(0, ctu_pkg::OFF_EDGE_CTL, 8'h00, r);
        chk(r, 8'h00, "measurement lost");
        chk({cur_on, dly}, 2'b00, "outputs cleared");
        $display("test reset done");
        finish_test();
    end
endmodule

`default_nettype wire

// ---- src/ctu_edge_ctrl.sv ----
/*
 * ctu_edge_ctrl: digital control of the charge-time unit. Three 8-bit
 * control registers on APB, two edge channels with source and polarity
 * select, sticky edge status, sequencing, discharge, delay pulse and
 * special event trigger.
 * Assumes idle_mode, sleep_mode, peripheral_disable and the two
 * capture-compare triggers come from pclk logic; edge pins and the
 * delay comparator are asynchronous and are synchronised here.
 */
// Summary of operation
// [R01] peripheral disable freezes unit, outputs off; source_discharge, current_range and current_trim stay driven from their bits
// [R02] any reset clears all unit registers
// [R03] reset abandons measurement, no result kept
// [R04] software discharges circuit after reset
// [R05] unit enable bit turns unit on
// [R06] stop in idle halts unit in idle
// [R07] delay generation bit enables delay pulse
// [R08] edge gate bit passes or blocks edges
// [R09] sequencing: edge two needs edge one first
// [R10] discharge bit grounds current source output
// [R11] trigger bit enables special event trigger
// [R12] edge two polarity: one rising, zero falling
// [R13] edge two source select, four sources
// [R14] edge one polarity: one rising, zero falling
// [R15] edge one source select, same encoding
// [R16] edge two status set on accepted event
// [R17] edge one status set on accepted event
// [R18] six-bit signed current trim field
// [R19] range field scales current, zero disables
// [R20] unimplemented control bit reads zero
// [R21] sleep forces current source off
// [R22] delay pulse driven on pulse output pin
// [R23] charge while edge one set, two clear
`timescale 1ns/10ps
`default_nettype none

module ctu_edge_ctrl (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [ctu_pkg::PADDR_W-1:0] paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        peripheral_disable,
    input  wire logic                        idle_mode,
    input  wire logic                        sleep_mode,
    input  wire logic                        edge_pin_one,
    input  wire logic                        edge_pin_two,
    input  wire logic                        capture_compare_one,
    input  wire logic                        capture_compare_two,
    input  wire logic                        delay_comparator,
    output logic                             current_on,
    output logic      [1:0]                  current_range,
    output logic      [5:0]                  current_trim,
    output logic                             charge_enable,
    output logic                             source_discharge,
    output logic                             delay_pulse_out,
    output logic                             special_trigger_out
);

    // whole block state in one packed struct
    typedef struct packed {
        logic [7:0]  charge_unit_control_high;
        logic [7:0]  charge_unit_edge_control;
        logic [7:0]  charge_unit_current_control;
        logic [2:0]  pin_meta;
        logic [2:0]  pin_sync;
        logic [3:0]  edge_prev;
        logic [31:0] rdata;
        logic        trig;
        logic        pulse;
    } ctu_state_s;

    ctu_state_s st_q;
    ctu_state_s st_d;

    // control fields, named after what they steer
    logic       unit_enable;
    logic       stop_in_idle;
    logic       delay_generation_enable;
    logic       edge_gate_enable;
    logic       edge_sequence_enable;
    logic       special_trigger_enable;
    logic       edge_one_status;
    logic       edge_two_status;
    logic       edge_pol [2];
    logic [1:0] edge_src [2];

    // internal strobes
    logic       running;
    logic       setup_ph;
    logic       access_ph;
    logic       addr_ok;
    logic       wr_high;
    logic       wr_edge;
    logic       wr_cur;
    logic [7:0] rd_byte;
    logic [1:0] lvl;
    logic [3:0] src_now;
    logic [1:0] hit;
    logic       accept_one;
    logic       accept_two;

    assign unit_enable  =
        st_q.charge_unit_control_high[ctu_pkg::B_UNIT_EN];
    assign stop_in_idle =
        st_q.charge_unit_control_high[ctu_pkg::B_STOP_IDLE];
    assign delay_generation_enable =
        st_q.charge_unit_control_high[ctu_pkg::B_DELAY_GEN];
    assign edge_gate_enable =
        st_q.charge_unit_control_high[ctu_pkg::B_EDGE_GATE];
    assign edge_sequence_enable =
        st_q.charge_unit_control_high[ctu_pkg::B_EDGE_SEQ];
    assign source_discharge =
        st_q.charge_unit_control_high[ctu_pkg::B_DISCHARGE]; // R10
    assign special_trigger_enable =
        st_q.charge_unit_control_high[ctu_pkg::B_TRIG_EN];

    // channel 0 is edge one, channel 1 is edge two
    assign edge_one_status =
        st_q.charge_unit_edge_control[ctu_pkg::B_E1_STAT];
    assign edge_two_status =
        st_q.charge_unit_edge_control[ctu_pkg::B_E2_STAT];
    assign edge_pol[0] =
        st_q.charge_unit_edge_control[ctu_pkg::B_E1_POL];
    assign edge_pol[1] =
        st_q.charge_unit_edge_control[ctu_pkg::B_E2_POL];
    assign edge_src[0] =
        st_q.charge_unit_edge_control[ctu_pkg::B_E1_SRC +: 2];
    assign edge_src[1] =
        st_q.charge_unit_edge_control[ctu_pkg::B_E2_SRC +: 2];

    // signed trim is passed as is to the analog trim ladder
    assign current_trim =
        st_q.charge_unit_current_control[ctu_pkg::B_TRIM +: 6]; // R18
    assign current_range =
        st_q.charge_unit_current_control[ctu_pkg::B_RANGE +: 2];

    // unit runs only when enabled, clocked and not parked in idle
    assign running = unit_enable // R05
        && !peripheral_disable // R01
        && !(idle_mode && stop_in_idle); // R06

    // current source: sleep wins over every other setting
    assign current_on = running
        && !sleep_mode // R21
        && (current_range != ctu_pkg::RNG_OFF); // R19

    // charging window opens on edge one, closes on edge two
    assign charge_enable = current_on // R23
        && edge_one_status && !edge_two_status
        && !source_discharge;

    assign delay_pulse_out     = st_q.pulse;
    assign special_trigger_out = st_q.trig;

    // apb decode; zero wait states, so pready is always high
    assign setup_ph  = psel && !penable;
    assign access_ph = psel && penable;
    assign addr_ok   = (paddr == ctu_pkg::OFF_CTL_HIGH)
                    || (paddr == ctu_pkg::OFF_EDGE_CTL)
                    || (paddr == ctu_pkg::OFF_CUR_CTL);
    assign pready    = 1'b1;
    assign pslverr   = access_ph && !addr_ok;
    assign prdata    = st_q.rdata;

    // a disabled module has no clock, so writes are dropped
    assign wr_high = access_ph && pwrite && !peripheral_disable
                  && (paddr == ctu_pkg::OFF_CTL_HIGH); // R01
    assign wr_edge = access_ph && pwrite && !peripheral_disable
                  && (paddr == ctu_pkg::OFF_EDGE_CTL);
    assign wr_cur  = access_ph && pwrite && !peripheral_disable
                  && (paddr == ctu_pkg::OFF_CUR_CTL);

    // read mux; unmapped and disabled reads give zero
    always_comb begin
        rd_byte = 8'h00;
        if (!peripheral_disable) begin
            if (paddr == ctu_pkg::OFF_CTL_HIGH) begin
                rd_byte = st_q.charge_unit_control_high
                        & ctu_pkg::CTL_HIGH_MSK; // R20
            end else if (paddr == ctu_pkg::OFF_EDGE_CTL) begin
                rd_byte = st_q.charge_unit_edge_control;
            end else if (paddr == ctu_pkg::OFF_CUR_CTL) begin
                rd_byte = st_q.charge_unit_current_control;
            end
        end
    end

    // per-channel source select and polarity edge detect;
    // each source keeps its own previous level, so a change of
    // the select never shows up as an edge on the new source
    always_comb begin
        src_now = 4'h0;
        src_now[ctu_pkg::SRC_PIN_ONE] = st_q.pin_sync[0];
        src_now[ctu_pkg::SRC_PIN_TWO] = st_q.pin_sync[1];
        src_now[ctu_pkg::SRC_CC_ONE]  = capture_compare_one;
        src_now[ctu_pkg::SRC_CC_TWO]  = capture_compare_two;
        for (int i = 0; i < 2; i++) begin
            lvl[i] = src_now[edge_src[i]]; // R13 R15
            // rising when polarity is one, falling when zero
            hit[i] = edge_pol[i] // R12 R14
                   ? (lvl[i] && !st_q.edge_prev[edge_src[i]])
                   : (!lvl[i] && st_q.edge_prev[edge_src[i]]);
        end
    end

    // gate, then order: edge two waits for edge one when sequenced
    assign accept_one = running && edge_gate_enable && hit[0]; // R08
    assign accept_two = running && edge_gate_enable && hit[1]
        && (!edge_sequence_enable || edge_one_status
            || accept_one); // R09

    // next-state logic
    always_comb begin
        st_d = st_q;

        // pins and comparator: two flops before anyone reads them
        st_d.pin_meta = {delay_comparator, edge_pin_two, edge_pin_one};
        st_d.pin_sync = st_q.pin_meta;

        // previous levels track only while clocked
        if (!peripheral_disable) begin
            st_d.edge_prev = src_now;
        end

        // read data latched in setup so prdata is a flop output
        if (setup_ph && !pwrite) begin
            st_d.rdata = {24'h000000, rd_byte};
        end

        if (wr_high) begin
            st_d.charge_unit_control_high =
                pwdata[7:0] & ctu_pkg::CTL_HIGH_MSK; // R20
        end
        if (wr_edge) begin
            st_d.charge_unit_edge_control = pwdata[7:0];
        end
        if (wr_cur) begin
            st_d.charge_unit_current_control = pwdata[7:0];
        end

        // hardware set beats a same-cycle software clear
        if (accept_one) begin
            st_d.charge_unit_edge_control[ctu_pkg::B_E1_STAT] =
                1'b1; // R17
        end
        if (accept_two) begin
            st_d.charge_unit_edge_control[ctu_pkg::B_E2_STAT] =
                1'b1; // R16
        end

        // one-cycle trigger to the converter on an accepted edge two
        st_d.trig = accept_two && special_trigger_enable; // R11

        // pulse lasts from edge one until the comparator trips
        st_d.pulse = running && delay_generation_enable // R07
            && st_d.charge_unit_edge_control[ctu_pkg::B_E1_STAT]
            && !st_q.pin_sync[2]; // R22
    end

    // state register; reset drops any measurement in flight
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0; // R02 R03
            st_q.charge_unit_control_high    <= ctu_pkg::RST_CTL_HIGH;
            st_q.charge_unit_edge_control    <= ctu_pkg::RST_EDGE_CTL;
            st_q.charge_unit_current_control <= ctu_pkg::RST_CUR_CTL;
        end else begin
            st_q <= st_d;
        end
    end

    // checks on the block's outputs and internal state
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // unimplemented bit always reads zero
    chk_unused_bit_zero: assert property ( // R20
        access_ph && !pwrite
        && $past(paddr) == ctu_pkg::OFF_CTL_HIGH
        |-> prdata[ctu_pkg::B_UNUSED] == 1'b0)
        else $error("unused control bit read as one");

    // a discharge write shows on the ground output next cycle
    chk_discharge_write: assert property ( // R10
        wr_high && pwdata[ctu_pkg::B_DISCHARGE]
        |=> source_discharge)
        else $error("discharge write did not ground source");

    // sleep turns the current source off at once
    chk_sleep_source_off: assert property ( // R21
        sleep_mode |-> !current_on && !charge_enable)
        else $error("current source on during sleep");

    // idle with stop-in-idle halts the source
    chk_idle_stop: assert property ( // R06
        idle_mode && stop_in_idle |-> !current_on)
        else $error("current source on in stopped idle");

    // range zero keeps the source off
    chk_range_off: assert property ( // R19
        current_range == ctu_pkg::RNG_OFF |-> !current_on)
        else $error("current source on with range off");

    // blocked edges never set edge one status
    chk_edge_blocked: assert property ( // R08
        !edge_gate_enable && !edge_one_status && !wr_edge
        |=> !edge_one_status)
        else $error("edge one set while edges blocked");

    // sequenced: edge two cannot precede edge one
    chk_edge_order: assert property ( // R09
        edge_sequence_enable && !edge_one_status
        && !edge_two_status && !wr_edge && !hit[0]
        |=> !edge_two_status)
        else $error("edge two accepted before edge one");

    // trigger only follows an enabled edge two status set
    chk_trigger_source: assert property ( // R11
        special_trigger_out
        |-> $past(special_trigger_enable) && edge_two_status)
        else $error("trigger without enable or edge two");

    // delay pulse requires delay generation
    chk_pulse_gate: assert property ( // R22
        delay_pulse_out |-> $past(delay_generation_enable)
        && $past(running))
        else $error("delay pulse without delay generation");

    // a disabled module answers reads with zero
    chk_disable_quiet: assert property ( // R01
        peripheral_disable && setup_ph && !pwrite
        |=> prdata == 32'h00000000)
        else $error("disabled module returned read data");

    // charging window closes one cycle after edge two is accepted
    chk_charge_window: assert property ( // R23
        accept_two |=> !charge_enable)
        else $error("charging continued after edge two");

    // unit disabled means source off
    chk_unit_off: assert property ( // R05
        !unit_enable |-> !current_on ##1 !$rose(edge_one_status)
        || $past(wr_edge))
        else $error("disabled unit acted on edges");

    // a control write sets the unit enable as written
    chk_enable_write: assert property ( // R05
        wr_high |=> unit_enable == $past(pwdata[ctu_pkg::B_UNIT_EN]))
        else $error("unit enable did not follow write");

    // an accepted edge one always leaves its status set
    chk_edge_one_set: assert property ( // R17
        accept_one |=> edge_one_status)
        else $error("edge one status not set");

    // an accepted edge two always leaves its status set
    chk_edge_two_set: assert property ( // R16
        accept_two |=> edge_two_status)
        else $error("edge two status not set");

    // a disabled module keeps its current settings
    chk_disable_holds: assert property ( // R01
        peripheral_disable
        |=> $stable(current_trim) && $stable(current_range))
        else $error("current settings changed while disabled");

endmodule

`default_nettype wire

// ---- src/ctu_pkg.sv ----
/*
 * ctu_pkg: constants shared by the charge-time edge control block:
 * register offsets, field positions, reset values and source codes.
 * Assumes a 32-bit APB with byte addresses; registers are 8 bits
 * wide and sit in the low byte of one aligned word each.
 */
package ctu_pkg;

    // apb address width and register byte offsets
    localparam int          PADDR_W = 8;
    localparam logic [7:0]  OFF_CTL_HIGH = 8'h00;
    localparam logic [7:0]  OFF_EDGE_CTL = 8'h04;
    localparam logic [7:0]  OFF_CUR_CTL  = 8'h08;

    // control high field positions
    localparam int          B_UNIT_EN    = 7;
    localparam int          B_UNUSED     = 6;
    localparam int          B_STOP_IDLE  = 5;
    localparam int          B_DELAY_GEN  = 4;
    localparam int          B_EDGE_GATE  = 3;
    localparam int          B_EDGE_SEQ   = 2;
    localparam int          B_DISCHARGE  = 1;
    localparam int          B_TRIG_EN    = 0;

    // edge control field positions (source fields give the lsb)
    localparam int          B_E2_POL     = 7;
    localparam int          B_E2_SRC     = 5;
    localparam int          B_E1_POL     = 4;
    localparam int          B_E1_SRC     = 2;
    localparam int          B_E2_STAT    = 1;
    localparam int          B_E1_STAT    = 0;

    // current control field positions
    localparam int          B_TRIM       = 2;
    localparam int          B_RANGE      = 0;

    // reset values; bit 6 of control high is not implemented
    localparam logic [7:0]  RST_CTL_HIGH = 8'h00;
    localparam logic [7:0]  RST_EDGE_CTL = 8'h00;
    localparam logic [7:0]  RST_CUR_CTL  = 8'h00;
    localparam logic [7:0]  CTL_HIGH_MSK = 8'hBF;

    // edge source encodings
    localparam logic [1:0]  SRC_PIN_ONE  = 2'h3;
    localparam logic [1:0]  SRC_PIN_TWO  = 2'h2;
    localparam logic [1:0]  SRC_CC_ONE   = 2'h1;
    localparam logic [1:0]  SRC_CC_TWO   = 2'h0;

    // current range encodings
    localparam logic [1:0]  RNG_HUNDRED  = 2'h3;
    localparam logic [1:0]  RNG_TEN      = 2'h2;
    localparam logic [1:0]  RNG_BASE     = 2'h1;
    localparam logic [1:0]  RNG_OFF      = 2'h0;

endpackage
